// [slft_pkg.sv]
// Constants, field layout and register map of the segment display frame timing block
package slft_pkg;
  localparam int unsigned SRC_CLK_MHZ = 100;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MEM_BYTES = 20;
  // Register byte offsets
  localparam logic [7:0] FRAME_RATE_OFS = 8'h00;
  localparam logic [7:0] CONTRAST_OFS = 8'h04;
  localparam logic [7:0] MODE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] MEM_BASE_OFS = 8'h40;
  localparam logic [7:0] MEM_LAST_OFS = 8'h8c;
  // Field positions
  localparam int unsigned PS_LSB = 4;
  localparam int unsigned CD_LSB = 0;
  localparam int unsigned DC_LSB = 5;
  localparam int unsigned CC_LSB = 0;
  localparam int unsigned DUTY_LSB = 0;
  localparam int unsigned BLANK_BIT = 2;
  // Writable masks; reserved bits read as zero
  localparam logic [7:0] FRAME_RATE_MASK = 8'h77;
  localparam logic [7:0] CONTRAST_MASK = 8'hef;
  localparam logic [7:0] MODE_MASK = 8'h07;
  // Reset values
  localparam logic [7:0] FRAME_RATE_RST = 8'h00;
  localparam logic [7:0] CONTRAST_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } slft_duty_t;
  // Frame factor K
  localparam logic [2:0] K_LAST_DEFAULT = 3'h7;
  localparam logic [2:0] K_LAST_THIRD = 3'h5;
  // Prescaler taps N per select code
  localparam int unsigned TAP_DIV [0:7] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  // Driver on-time in microseconds per code 0..6; code 7 is half a prescaled period
  localparam int unsigned DRIVE_US [0:6] = '{300, 70, 150, 450, 575, 850, 1150};
  localparam logic [2:0] DRIVE_CODE_HALF = 3'h7;
endpackage

// [slft_frame_timing.sv]
// Segment display frame timing: prescaler, frame counter, drive time, contrast and display memory
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module slft_frame_timing #(
  parameter int unsigned DRIVE_CYCLES [0:6] = '{
    slft_pkg::DRIVE_US[0] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[1] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[2] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[3] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[4] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[5] * slft_pkg::SRC_CLK_MHZ,
    slft_pkg::DRIVE_US[6] * slft_pkg::SRC_CLK_MHZ}
) (
  input wire logic mclk, // Display source clock, 100 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [slft_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic prescaled_display_clock, // Prescaled display clock
  output logic frame_start, // One-cycle frame boundary strobe
  output logic drive_on, // Drivers on after a transition
  output logic [3:0] max_drive_voltage, // Applied contrast level code
  output logic [3:0] com_out, // Active common lines, one-hot
  output logic [24:0] seg_out // Energized segments of active common
);
  logic [7:0] frame_rate_q;
  logic [7:0] contrast_q;
  logic [7:0] mode_q;
  logic [7:0] mem_q [0:slft_pkg::MEM_BYTES-1];
  logic [11:0] pre_cnt_q;
  logic [2:0] div_cnt_q;
  logic [15:0] per_cnt_q;
  logic [2:0] frame_phase_q;
  logic blank_active_q;
  logic [16:0] drv_cnt_q;
  logic per_ok_q;
  logic frame_ok_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic clk_q;
  logic frame_start_q;
  logic drive_on_q;
  logic [3:0] voltage_q;
  logic [3:0] com_out_q;
  logic [24:0] seg_out_q;
  logic [11:0] tap_last;
  logic [2:0] cd;
  logic [15:0] period;
  logic [15:0] half;
  logic tap_tick;
  logic ps_tick;
  logic [2:0] k_last;
  logic frame_end;
  logic [16:0] drv_sel;
  logic [16:0] drv_lim;
  logic [1:0] duty;
  logic [1:0] com_idx;
  logic access;
  logic wr_en;

  // Byte index of a display memory address, or MEM_BYTES when not one
  function automatic logic [4:0] mem_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - slft_pkg::MEM_BASE_OFS;
    if (a >= slft_pkg::MEM_BASE_OFS && a <= slft_pkg::MEM_LAST_OFS && a[1:0] == 2'b00)
      mem_index = rel[6:2];
    else
      mem_index = 5'(slft_pkg::MEM_BYTES);
  endfunction

  // Segments of common c: bytes 5c..5c+3, only bit 0 of byte 5c+3
  function automatic logic [24:0] seg_of(input logic [1:0] c);
    logic [4:0] b;
    b = 5'(5 * c);
    seg_of = {mem_q[b + 5'd3][0], mem_q[b + 5'd2], mem_q[b + 5'd1], mem_q[b]};
  endfunction

  // Common line served at a given frame phase
  function automatic logic [1:0] common_of(input logic [1:0] d, input logic [2:0] ph);
    unique case (d)
      slft_pkg::DUTY_STATIC: common_of = 2'd0;
      slft_pkg::DUTY_HALF: common_of = {1'b0, ph[2]};
      // A third-duty frame stretched by a duty change never reaches the fourth common
      slft_pkg::DUTY_THIRD: common_of = (ph[2:1] == 2'd3) ? 2'd2 : ph[2:1];
      default: common_of = ph[2:1];
    endcase
  endfunction

  assign duty = mode_q[slft_pkg::DUTY_LSB +: 2];
  assign cd = frame_rate_q[slft_pkg::CD_LSB +: 3];
  assign tap_last = 12'(slft_pkg::TAP_DIV[frame_rate_q[slft_pkg::PS_LSB +: 3]] - 1);
  assign period = 16'(slft_pkg::TAP_DIV[frame_rate_q[slft_pkg::PS_LSB +: 3]] * (cd + 1));
  assign half = {1'b0, period[15:1]};
  assign tap_tick = pre_cnt_q >= tap_last;
  assign ps_tick = tap_tick && div_cnt_q >= cd;
  assign k_last = (duty == slft_pkg::DUTY_THIRD) ? slft_pkg::K_LAST_THIRD : slft_pkg::K_LAST_DEFAULT;
  assign frame_end = ps_tick && frame_phase_q >= k_last;
  assign com_idx = common_of(duty, frame_phase_q);
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite && pstrb[0];

  always_comb
  begin
    drv_sel = 17'(DRIVE_CYCLES[0]);
    if (contrast_q[slft_pkg::DC_LSB +: 3] != slft_pkg::DRIVE_CODE_HALF)
      drv_sel = 17'(DRIVE_CYCLES[contrast_q[slft_pkg::DC_LSB +: 3]]);
    if (duty == slft_pkg::DUTY_STATIC || blank_active_q || contrast_q[slft_pkg::DC_LSB +: 3] == slft_pkg::DRIVE_CODE_HALF)
      drv_lim = {1'b0, half};
    else if (drv_sel > {1'b0, half})
      drv_lim = {1'b0, half};
    else
      drv_lim = drv_sel;
  end

  // APB slave: one wait cycle, ready and data from flip-flops
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      if (psel && penable && !pready_q)
      begin
        unique case (paddr)
          slft_pkg::FRAME_RATE_OFS: prdata_q <= {24'h0, frame_rate_q};
          slft_pkg::CONTRAST_OFS: prdata_q <= {24'h0, contrast_q};
          slft_pkg::MODE_OFS: prdata_q <= {24'h0, mode_q};
          slft_pkg::STATUS_OFS: prdata_q <= {25'h0, frame_phase_q, 2'b00, drive_on_q, blank_active_q};
          default:
          begin
            if (mem_index(paddr) < 5'(slft_pkg::MEM_BYTES))
              prdata_q <= {24'h0, mem_q[mem_index(paddr)]};
            else
              pslverr_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_rate_q <= slft_pkg::FRAME_RATE_RST;
      contrast_q <= slft_pkg::CONTRAST_RST;
      mode_q <= slft_pkg::MODE_RST;
    end
    else if (wr_en)
    begin
      if (paddr == slft_pkg::FRAME_RATE_OFS)
        frame_rate_q <= pwdata[7:0] & slft_pkg::FRAME_RATE_MASK;
      if (paddr == slft_pkg::CONTRAST_OFS)
        contrast_q <= pwdata[7:0] & slft_pkg::CONTRAST_MASK;
      if (paddr == slft_pkg::MODE_OFS)
        mode_q <= pwdata[7:0] & slft_pkg::MODE_MASK;
    end
  end

  // Display memory, every bit read/write
  generate
    for (genvar i = 0; i < slft_pkg::MEM_BYTES; i++)
    begin : g_mem
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          mem_q[i] <= slft_pkg::MEM_RST;
        else if (wr_en && mem_index(paddr) == 5'(i))
          mem_q[i] <= pwdata[7:0];
      end
    end
  endgenerate

  // Two-stage prescaler and prescaled clock
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_cnt_q <= 12'h0;
      div_cnt_q <= 3'h0;
      per_cnt_q <= 16'h0;
      clk_q <= 1'b0;
    end
    else
    begin
      pre_cnt_q <= tap_tick ? 12'h0 : pre_cnt_q + 12'h1;
      if (ps_tick)
        div_cnt_q <= 3'h0;
      else if (tap_tick)
        div_cnt_q <= div_cnt_q + 3'h1;
      per_cnt_q <= ps_tick ? 16'h0 : per_cnt_q + 16'h1;
      // Rises only at a tick, so a larger divider written mid-period adds no extra edge
      clk_q <= ps_tick || (clk_q && (per_cnt_q + 16'h1) < half);
    end
  end

  // Frame counter, frame strobe, applied contrast and blanking
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_phase_q <= 3'h0;
      frame_start_q <= 1'b0;
      voltage_q <= 4'h0;
      blank_active_q <= 1'b0;
    end
    else
    begin
      frame_start_q <= frame_end;
      if (ps_tick)
        frame_phase_q <= frame_end ? 3'h0 : frame_phase_q + 3'h1;
      if (frame_end)
      begin
        voltage_q <= contrast_q[slft_pkg::CC_LSB +: 4];
        blank_active_q <= mode_q[slft_pkg::BLANK_BIT];
      end
    end
  end

  // Driver on-time after each transition
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      drv_cnt_q <= 17'h0;
      drive_on_q <= 1'b0;
    end
    else if (ps_tick)
    begin
      drv_cnt_q <= drv_lim - 17'h1;
      drive_on_q <= 1'b1;
    end
    else if (drv_cnt_q != 17'h0)
      drv_cnt_q <= drv_cnt_q - 17'h1;
    else
      drive_on_q <= 1'b0;
  end

  // Common and segment outputs
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      com_out_q <= 4'h0;
      seg_out_q <= 25'h0;
    end
    else if (blank_active_q)
    begin
      com_out_q <= 4'h0;
      seg_out_q <= 25'h0;
    end
    else
    begin
      com_out_q <= 4'h1 << com_idx;
      seg_out_q <= seg_of(com_idx);
    end
  end

  // Period check helper: set at the first tick after a frame rate write, so the next period is full
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      per_ok_q <= 1'b0;
    else if (wr_en && paddr == slft_pkg::FRAME_RATE_OFS)
      per_ok_q <= 1'b0;
    else if (ps_tick)
      per_ok_q <= 1'b1;
  end

  // Frame check helper: no mode write since the previous frame boundary
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      frame_ok_q <= 1'b0;
    else if (wr_en && paddr == slft_pkg::MODE_OFS)
      frame_ok_q <= 1'b0;
    else if (frame_end)
      frame_ok_q <= 1'b1;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prescaled_display_clock = clk_q;
  assign frame_start = frame_start_q;
  assign drive_on = drive_on_q;
  assign max_drive_voltage = voltage_q;
  assign com_out = com_out_q;
  assign seg_out = seg_out_q;

  a_ps_period: assert property (@(posedge mclk) disable iff (!nrst)
    ps_tick && per_ok_q |-> per_cnt_q == period - 16'h1)
    else $error("prescaled period differs from N*D");
  a_frame_len: assert property (@(posedge mclk) disable iff (!nrst)
    frame_start_q && $past(frame_ok_q) |-> frame_phase_q == 3'h0 && $past(frame_phase_q) ==
      (($past(duty) == slft_pkg::DUTY_THIRD) ? slft_pkg::K_LAST_THIRD : slft_pkg::K_LAST_DEFAULT))
    else $error("frame length does not match K");
  a_drive_cap: assert property (@(posedge mclk) disable iff (!nrst)
    drive_on_q && per_ok_q |-> per_cnt_q < half)
    else $error("drive time exceeds half period");
  a_drive_half: assert property (@(posedge mclk) disable iff (!nrst)
    ps_tick && (duty == slft_pkg::DUTY_STATIC || blank_active_q) |=> drv_cnt_q == $past({1'b0, half}) - 17'h1)
    else $error("static or blank drive time not half period");
  a_drive_code: assert property (@(posedge mclk) disable iff (!nrst)
    ps_tick && duty != slft_pkg::DUTY_STATIC && !blank_active_q
      && contrast_q[slft_pkg::DC_LSB +: 3] == 3'h1 && {1'b0, half} >= 17'(DRIVE_CYCLES[1])
      |=> drv_cnt_q == 17'(DRIVE_CYCLES[1]) - 17'h1)
    else $error("drive time code not applied");
  a_contrast_hold: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(voltage_q) |-> frame_start_q)
    else $error("contrast changed outside frame start");
  a_seg_map: assert property (@(posedge mclk) disable iff (!nrst)
    com_out_q[1] |-> seg_out_q == $past({mem_q[8][0], mem_q[7], mem_q[6], mem_q[5]}))
    else $error("segments of common one mismatch memory");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
    pready_q && !pwrite && paddr == slft_pkg::FRAME_RATE_OFS |-> prdata_q[7] == 1'b0 && prdata_q[3] == 1'b0)
    else $error("reserved frame rate bits read nonzero");
  a_duty_commons: assert property (@(posedge mclk) disable iff (!nrst)
    com_out_q[3] |-> $past(duty) == slft_pkg::DUTY_QUARTER)
    else $error("fourth common active outside quarter duty");
  a_blank_ground: assert property (@(posedge mclk) disable iff (!nrst)
    blank_active_q |=> com_out_q == 4'h0 && seg_out_q == 25'h0)
    else $error("outputs not grounded while blanked");
  a_strobe_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    frame_start_q |=> !frame_start_q)
    else $error("frame strobe longer than one cycle");
  a_clk_rise: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(clk_q) |-> $past(ps_tick))
    else $error("prescaled clock rose without a tick");
  a_mem_storage: assert property (@(posedge mclk) disable iff (!nrst)
    wr_en && paddr == slft_pkg::MEM_BASE_OFS + 8'h10 |=> mem_q[4] == $past(pwdata[7:0]))
    else $error("unused memory byte not stored");

  c_frame_third: cover property (@(posedge mclk) disable iff (!nrst)
    frame_start_q && duty == slft_pkg::DUTY_THIRD);
  c_blank_entry: cover property (@(posedge mclk) disable iff (!nrst)
    $rose(blank_active_q));
  c_contrast_apply: cover property (@(posedge mclk) disable iff (!nrst)
    $changed(voltage_q));
  c_unmapped_err: cover property (@(posedge mclk) disable iff (!nrst)
    pslverr_q);
endmodule // slft_frame_timing
`default_nettype wire

// [slft_panel_model.sv]
// Panel model: records the segment pattern last shown on each common line
`timescale 1ns/1ps
`default_nettype none
module slft_panel_model (
  input wire logic mclk, // Source clock
  input wire logic nrst, // Reset, active low
  input wire logic [3:0] com_out, // Common lines
  input wire logic [24:0] seg_out, // Segment lines
  output logic [24:0] seen [0:3], // Last pattern per common
  output logic multi_com // Two commons were active at once
);
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      multi_com <= 1'b0;
      for (int c = 0; c < 4; c++)
        seen[c] <= '0;
    end
    else
    begin
      if ($countones(com_out) > 1)
        multi_com <= 1'b1;
      for (int c = 0; c < 4; c++)
        if (com_out[c] === 1'b1)
          seen[c] <= seg_out;
    end
  end
endmodule // slft_panel_model
`default_nettype wire

// [slft_frame_timing_tb_top.sv]
// Testbench for the segment display frame timing block
`timescale 1ns/1ps
`default_nettype none
module slft_frame_timing_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pdc, frame_start, drive_on, multi_com, err;
  logic pdc_q = 1'b0;
  logic don_q = 1'b0;
  logic [3:0] max_drive_voltage, com_out;
  logic [24:0] seg_out;
  logic [24:0] seen [0:3];
  int bad_count = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    pdc_q <= pdc;
    don_q <= drive_on;
  end
  slft_frame_timing #(.DRIVE_CYCLES('{30, 7, 15, 45, 57, 85, 115})) slft_frame_timing_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaled_display_clock(pdc), .frame_start(frame_start), .drive_on(drive_on),
    .max_drive_voltage(max_drive_voltage), .com_out(com_out), .seg_out(seg_out)
  );
  slft_panel_model slft_panel_model_i (
    .mclk(mclk), .nrst(nrst), .com_out(com_out), .seg_out(seg_out), .seen(seen), .multi_com(multi_com)
  );
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 2, "pready latency");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, exp}, "read data");
    check({31'h0, err}, {31'h0, e}, "slave error");
  endtask
  function automatic bit ev(input bit sel);
    return sel ? (pdc === 1'b1 && pdc_q === 1'b0) : (frame_start === 1'b1);
  endfunction
  // Cycles between two events: prescaled clock rise or frame start
  task automatic period(input bit sel, input int exp);
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (!ev(sel) && n < 70000);
    end
    check(n, exp, "period");
  endtask
  task automatic on_time(input int exp);
    int n;
    n = 0;
    // Skip one rise: it may have been launched before the last write landed
    repeat (2)
      do
        @(posedge mclk);
      while (!(drive_on === 1'b1 && don_q === 1'b0));
    while (drive_on === 1'b1 && n < 70000)
    begin
      @(posedge mclk);
      n++;
    end
    check(n, exp, "drive on-time");
  endtask
  function automatic logic [7:0] mb(input int i);
    return 8'(i * 37 + 91);
  endfunction
  task automatic t_regs();
    rd_chk(slft_pkg::FRAME_RATE_OFS, 8'h00, 1'b0);
    rd_chk(slft_pkg::CONTRAST_OFS, 8'h00, 1'b0);
    apb(1'b1, slft_pkg::FRAME_RATE_OFS, 8'hff);
    rd_chk(slft_pkg::FRAME_RATE_OFS, 8'h77, 1'b0);
    apb(1'b1, slft_pkg::CONTRAST_OFS, 8'h1f);
    rd_chk(slft_pkg::CONTRAST_OFS, 8'h0f, 1'b0);
    rd_chk(8'h30, 8'h00, 1'b1);
  endtask
  task automatic t_divide();
    for (int p = 0; p < 8; p++)
    begin
      apb(1'b1, slft_pkg::FRAME_RATE_OFS, 8'(p << 4));
      period(1'b1, slft_pkg::TAP_DIV[p]);
    end
    apb(1'b1, slft_pkg::FRAME_RATE_OFS, 8'h07);
    period(1'b1, 128);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, slft_pkg::MODE_OFS, 8'(m));
      period(1'b0, (m == 2 ? 6 : 8) * 128);
    end
  endtask
  task automatic t_memory();
    logic [7:0] b3;
    apb(1'b1, slft_pkg::FRAME_RATE_OFS, 8'h00);
    apb(1'b1, slft_pkg::MODE_OFS, 8'h03);
    for (int i = 0; i < 20; i++)
      apb(1'b1, 8'(slft_pkg::MEM_BASE_OFS + 4 * i), mb(i));
    pstrb <= 4'he;
    apb(1'b1, slft_pkg::MEM_BASE_OFS, 8'h00);
    pstrb <= 4'hf;
    for (int i = 0; i < 20; i++)
      rd_chk(8'(slft_pkg::MEM_BASE_OFS + 4 * i), mb(i), 1'b0);
    period(1'b0, 128);
    for (int c = 0; c < 4; c++)
    begin
      b3 = mb(5 * c + 3);
      check(seen[c], {b3[0], mb(5 * c + 2), mb(5 * c + 1), mb(5 * c)}, "segments");
    end
    check({31'h0, multi_com}, 32'h0, "one common at a time");
  endtask
  task automatic t_contrast();
    period(1'b0, 128);
    apb(1'b1, slft_pkg::CONTRAST_OFS, 8'h0a);
    check(max_drive_voltage, 4'hf, "contrast held until frame start");
    period(1'b0, 128);
    check(max_drive_voltage, 4'ha, "contrast applied at frame start");
    @(posedge mclk);
    check({31'h0, frame_start}, 32'h0, "frame strobe one cycle");
  endtask
  task automatic t_drive();
    int code [0:3] = '{0, 1, 3, 7};
    int exp [0:3] = '{30, 7, 32, 32};
    apb(1'b1, slft_pkg::FRAME_RATE_OFS, 8'h10);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, slft_pkg::CONTRAST_OFS, 8'(code[k] << 5));
      on_time(exp[k]);
    end
    apb(1'b1, slft_pkg::CONTRAST_OFS, 8'h20);
    apb(1'b1, slft_pkg::MODE_OFS, 8'h00);
    on_time(32);
  endtask
  task automatic t_blank();
    apb(1'b1, slft_pkg::MODE_OFS, 8'h03);
    period(1'b0, 512);
    apb(1'b1, slft_pkg::MODE_OFS, 8'h07);
    check({31'h0, com_out === 4'h0}, 32'h0, "blank waits for frame end");
    period(1'b0, 512);
    @(posedge mclk);
    check({com_out, 3'h0, seg_out}, 32'h0, "outputs low when blanked");
    on_time(32);
    check({com_out, 3'h0, seg_out}, 32'h0, "outputs stay low");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_divide();
    t_memory();
    t_contrast();
    t_drive();
    t_blank();
    test_done();
  end
  initial
  begin
    #1000000;
    bad_count++;
    test_done();
  end
endmodule // slft_frame_timing_tb_top
`default_nettype wire
